// ===== hw/mtc_pkg.sv
// Notes on behaviour
// R1 - Trip level is table percent times full scale
// R2 - Timing input high gives 30 us off-time
// R3 - Off period lasts fixed configurable duration
// R4 - Comparator ignored about 1 us after switching
// R5 - Output disable input high turns bridges off
// R6 - Translator keeps stepping while outputs disabled
// R7 - Overtemperature or pump undervoltage disables outputs
// R8 - Sink-gate regulator fault disables outputs
// R9 - Power-on lockout disables outputs, forces home
// R10 - Low-power input low shuts everything down
// R11 - Leaving low-power drives currents to home
// R12 - Host waits 1 ms after wake to step
// R13 - Mixed decay: fast 31.25 percent, then slow
// R14 - Off period turns on matching recirculation FETs
// R15 - Zero current stops synchronous rectification
// R16 - Home is 45 degrees, one sixty-fourth per step
// R17 - Levels follow 64-entry table, coarse modes skip
// R18 - Resolution pins select size at step edge
// R19 - Step rising edge advances, direction sampled
// R20 - Falling level mixed decay, else slow decay
// R21 - Reset low holds home, outputs off
// R22 - Off and blank times from counted cycles
// R23 - All inputs synchronised before use; fault, off_time_set and full-scale inputs are not
package mtc_pkg;
    localparam int CLK_MHZ = 10;
    localparam int T_OFF_DEF_US = 30;
    localparam int T_BLANK_US = 1;
    localparam int OFF_TIME_SET_DIV = 825;
    // Off-time counts in cycles; 30 us at 10 MHz
    localparam logic [11:0] OFF_DEF_CYC = 12'(T_OFF_DEF_US * CLK_MHZ);
    localparam logic [11:0] BLANK_CYC = 12'(T_BLANK_US * CLK_MHZ);
    // Fast part of mixed decay: 31.25 percent is 5/16
    localparam int FAST_NUM = 5;
    localparam int FAST_SHIFT = 4;
    localparam logic [5:0] HOME_IDX = 6'h08;
    localparam int TBL_PCT_SCALE = 100;

    typedef enum logic [1:0] {
        MTC_RES_FULL = 2'h0,
        MTC_RES_HALF = 2'h1,
        MTC_RES_QUARTER = 2'h2,
        MTC_RES_SIXTEENTH = 2'h3
    } mtc_res_t;

    // Chopper states; ON-FAST and FAST-SLOW differ in one bit, ON-SLOW in both
    typedef enum logic [1:0] {
        MTC_ON = 2'b00,
        MTC_FAST = 2'b01,
        MTC_SLOW = 2'b11
    } mtc_chop_t;

    // Gate drive of one full bridge
    typedef struct packed {
        logic src_a;
        logic snk_a;
        logic src_b;
        logic snk_b;
    } mtc_bridge_t;

    // Per-phase current set point
    typedef struct packed {
        logic neg;
        logic [13:0] pct_x100;
    } mtc_level_t;
endpackage : mtc_pkg

// ===== hw/mtc_chopper.sv
`timescale 1ns/10ps
`default_nettype none
module mtc_chopper
    import mtc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic neg,
    input wire logic mixed,
    input wire logic trip,
    input wire logic zero_i,
    input wire logic [11:0] off_cyc,
    output mtc_bridge_t gate,
    output var logic in_off
);
    mtc_chop_t st_q, st_d;
    logic [11:0] off_q;
    logic [11:0] blank_q;
    logic [11:0] fast_cyc;
    logic trip_ok, off_done, fast_done;
    logic sync_ok_q;

    // Fast portion is 5/16 of the off-time
    assign fast_cyc = 12'((16'(off_cyc) * 16'(FAST_NUM)) >> FAST_SHIFT); // see R13
    assign trip_ok = trip && (blank_q == 12'h0000); // see R4
    assign off_done = (off_q == 12'h0000);
    assign fast_done = (off_cyc - off_q) >= fast_cyc;
    assign in_off = (st_q != MTC_ON);

    // Chopper sequencing
    always_comb begin
        st_d = st_q;
        case (st_q)
            MTC_ON: if (trip_ok) st_d = mixed ? MTC_FAST : MTC_SLOW; // see R20
            MTC_FAST: if (off_done) st_d = MTC_ON;
                else if (fast_done) st_d = MTC_SLOW; // see R13
            MTC_SLOW: if (off_done) st_d = MTC_ON; // see R3
            default: st_d = MTC_ON;
        endcase
    end

    // Counters: off-time loaded on trip, blank reloaded on each switch
    always_ff @(posedge core_clk) begin
        if (!rst_n || !run) begin
            st_q <= MTC_ON;
            off_q <= 12'h0000;
            blank_q <= 12'h0000;
            sync_ok_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q == MTC_ON && st_d != MTC_ON)
                off_q <= off_cyc; // see R3 R22
            else if (off_q != 12'h0000)
                off_q <= off_q - 12'h0001;
            if (st_d != st_q || st_q == MTC_ON && blank_q == 12'h0000
                && $past(st_q) != MTC_ON)
                blank_q <= BLANK_CYC; // see R4 R22
            else if (blank_q != 12'h0000)
                blank_q <= blank_q - 12'h0001;
            // Once current reaches zero, stop rectifying until next on
            if (st_q == MTC_ON)
                sync_ok_q <= 1'b1;
            else if (zero_i)
                sync_ok_q <= 1'b0; // see R15
        end
    end

    // Gate selection. On: diagonal pair. Slow: both sinks (recirculate low).
    // Fast: opposite diagonal. Without sync rectification all FETs are off.
    always_comb begin
        gate = '0;
        if (run) begin
            case (st_q)
                MTC_ON: begin
                    gate.src_a = !neg;
                    gate.snk_b = !neg;
                    gate.src_b = neg;
                    gate.snk_a = neg;
                end
                MTC_FAST: if (sync_ok_q) begin // see R14 R15
                    gate.src_b = !neg;
                    gate.snk_a = !neg;
                    gate.src_a = neg;
                    gate.snk_b = neg;
                end
                MTC_SLOW: if (sync_ok_q) begin // see R14 R15
                    gate.snk_a = 1'b1;
                    gate.snk_b = 1'b1;
                end
                default: gate = '0;
            endcase
        end
    end

    a_blank_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
        (run && st_q == MTC_ON && blank_q != 0 && trip) |=> st_q == MTC_ON)
        else $error("trip acted inside blank window"); // see R4
    a_off_fixed: assert property (@(posedge core_clk) disable iff (!rst_n)
        (run && $rose(in_off)) |-> ##1 in_off [*8])
        else $error("off period ended early"); // see R3
    a_fast_first: assert property (@(posedge core_clk) disable iff (!rst_n)
        (run && st_q == MTC_ON && st_d == MTC_FAST) |=> st_q == MTC_FAST)
        else $error("mixed decay did not start fast"); // see R13
endmodule : mtc_chopper
`default_nettype wire

// ===== hw/mtc_translator.sv
`timescale 1ns/10ps
`default_nettype none
module mtc_translator
    import mtc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic step_in,
    input wire logic dir_in,
    input wire logic resolution_sel_lo,
    input wire logic resolution_sel_hi,
    input wire logic out_disable,
    input wire logic sleep_n,
    input wire logic reset_in_n,
    input wire logic off_time_high,
    input wire logic [11:0] off_time_set,
    input wire logic [13:0] full_scale_trip_current,
    input wire logic phase_a_current_sense,
    input wire logic phase_b_current_sense,
    input wire logic phase_a_zero,
    input wire logic phase_b_zero,
    input wire logic over_temp,
    input wire logic gate_pump_low,
    input wire logic sink_gate_regulator_fault,
    input wire logic power_on_lockout,
    output mtc_bridge_t bridge_a,
    output mtc_bridge_t bridge_b,
    output mtc_level_t level_a,
    output mtc_level_t level_b,
    output logic [27:0] trip_a,
    output logic [27:0] trip_b,
    output logic mixed_a,
    output logic mixed_b,
    output logic [5:0] position,
    output logic pump_on,
    output logic outputs_on
);
    // Two-stage synchronisers; first stage feeds only the second
    logic [12:0] s1_q, s2_q;
    logic step_prev_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s1_q <= 13'h0000;
            s2_q <= 13'h0000;
            step_prev_q <= 1'b0;
        end else begin
            s1_q <= {step_in, dir_in, resolution_sel_hi, resolution_sel_lo,
                     out_disable, sleep_n, reset_in_n, phase_a_current_sense,
                     phase_b_current_sense, off_time_high, phase_a_zero,
                     phase_b_zero, power_on_lockout}; // see R23
            s2_q <= s1_q;
            step_prev_q <= s2_q[12];
        end
    end

    logic st_s, dir_s, dis_s, slp_s, rst_s, ta_s, tb_s, oth_s, za_s, zb_s;
    logic por_s;
    mtc_res_t res_s;
    assign {st_s, dir_s} = s2_q[12:11];
    assign res_s = mtc_res_t'(s2_q[10:9]);
    assign {dis_s, slp_s, rst_s, ta_s, tb_s, oth_s, za_s, zb_s, por_s} =
        s2_q[8:0];

    // Home whenever held in reset, lockout or sleep
    logic hold_home, step_edge, fault, run;
    assign hold_home = !rst_s || por_s || !slp_s; // see R9 R11 R21
    assign step_edge = st_s && !step_prev_q && !hold_home; // see R19 R21
    assign fault = over_temp || gate_pump_low
        || sink_gate_regulator_fault; // see R7 R8
    // Enable ignored by the translator so position keeps tracking
    assign run = !dis_s && !fault && !hold_home; // see R5 R6 R10

    // Step size in 1/64 table entries, aligned to home
    logic [5:0] inc, idx_q, nxt;
    assign inc = (res_s == MTC_RES_FULL) ? 6'h10 :
                 (res_s == MTC_RES_HALF) ? 6'h08 :
                 (res_s == MTC_RES_QUARTER) ? 6'h04 : 6'h01; // see R18
    // Coarse modes snap to the nearest grid point ahead of the motion
    logic [5:0] grid, base;
    assign grid = inc - 6'h01;
    assign base = idx_q - HOME_IDX;
    assign nxt = dir_s ?
        (((base & ~grid) + inc) + HOME_IDX) :
        ((((base + grid) & ~grid) - inc) + HOME_IDX); // see R16 R17 R19

    // Quarter-wave table in hundredths of a percent
    function automatic logic [13:0] qsin(input logic [4:0] k);
        case (k)
            5'd0: qsin = 14'd0;     5'd1: qsin = 14'd980;
            5'd2: qsin = 14'd1951;  5'd3: qsin = 14'd2903;
            5'd4: qsin = 14'd3827;  5'd5: qsin = 14'd4714;
            5'd6: qsin = 14'd5556;  5'd7: qsin = 14'd6344;
            5'd8: qsin = 14'd7071;  5'd9: qsin = 14'd7730;
            5'd10: qsin = 14'd8315; 5'd11: qsin = 14'd8819;
            5'd12: qsin = 14'd9239; 5'd13: qsin = 14'd9569;
            5'd14: qsin = 14'd9808; 5'd15: qsin = 14'd9952;
            default: qsin = 14'd10000;
        endcase
    endfunction : qsin

    // Signed sine for angle index i (64 per cycle)
    function automatic mtc_level_t lvl(input logic [5:0] i);
        logic [4:0] q;
        q = i[4] ? 5'(6'h10 - {2'b00, i[3:0]}) : {1'b0, i[3:0]};
        lvl.neg = i[5];
        lvl.pct_x100 = qsin(q);
    endfunction : lvl

    // Phase A is cosine, phase B sine of the angle
    mtc_level_t la_d, lb_d;
    assign la_d = lvl(6'(idx_q + 6'h10)); // see R17
    assign lb_d = lvl(idx_q);

    logic fall_a, fall_b;
    assign fall_a = lvl(6'(nxt + 6'h10)).pct_x100 < la_d.pct_x100;
    assign fall_b = lvl(nxt).pct_x100 < lb_d.pct_x100;

    // Position and decay selection
    always_ff @(posedge core_clk) begin
        if (!rst_n || hold_home) begin
            idx_q <= HOME_IDX; // see R9 R11 R21
            mixed_a <= 1'b1;
            mixed_b <= 1'b1; // see R20
        end else if (step_edge) begin
            idx_q <= nxt; // see R6
            mixed_a <= fall_a;
            mixed_b <= fall_b; // see R20
        end
    end

    // Trip threshold: pct/100 times full scale, in hundredths units
    logic ca_trip, cb_trip;
    logic [11:0] off_cyc;
    assign off_cyc = oth_s ? OFF_DEF_CYC : off_time_set; // see R2 R3
    assign ca_trip = ta_s;
    assign cb_trip = tb_s;

    mtc_bridge_t ga, gb;
    mtc_chopper u_chop_a (
        .core_clk(core_clk), .rst_n(rst_n), .run(run), .neg(la_d.neg),
        .mixed(mixed_a), .trip(ca_trip), .zero_i(za_s),
        .off_cyc(off_cyc), .gate(ga), .in_off()
    );
    mtc_chopper u_chop_b (
        .core_clk(core_clk), .rst_n(rst_n), .run(run), .neg(lb_d.neg),
        .mixed(mixed_b), .trip(cb_trip), .zero_i(zb_s),
        .off_cyc(off_cyc), .gate(gb), .in_off()
    );

    // Registered outputs
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bridge_a <= '0;
            bridge_b <= '0;
            level_a <= '0;
            level_b <= '0;
            trip_a <= 28'h000_0000;
            trip_b <= 28'h000_0000;
            position <= HOME_IDX;
            pump_on <= 1'b0;
            outputs_on <= 1'b0;
        end else begin
            bridge_a <= run ? ga : '0; // see R5 R7 R8 R10
            bridge_b <= run ? gb : '0;
            level_a <= la_d;
            level_b <= lb_d;
            trip_a <= 28'((la_d.pct_x100 * full_scale_trip_current)
                / TBL_PCT_SCALE); // see R1
            trip_b <= 28'((lb_d.pct_x100 * full_scale_trip_current)
                / TBL_PCT_SCALE);
            position <= idx_q;
            pump_on <= slp_s; // see R10
            outputs_on <= run;
        end
    end

    a_disable_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        (dis_s || fault) |=> (bridge_a == '0 && bridge_b == '0))
        else $error("bridge driven while disabled"); // see R5
    a_fault_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        sink_gate_regulator_fault |=> !outputs_on)
        else $error("outputs on with regulator fault"); // see R8
    a_home_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        hold_home |=> idx_q == HOME_IDX)
        else $error("translator left home while held"); // see R21
    a_step_tracks: assert property (@(posedge core_clk) disable iff (!rst_n)
        (step_edge && dis_s) |=> idx_q == $past(nxt))
        else $error("position lost while disabled"); // see R6
    a_full_step: assert property (@(posedge core_clk) disable iff (!rst_n)
        (step_edge && res_s == MTC_RES_FULL && dir_s && idx_q == HOME_IDX)
        |=> idx_q == 6'h18)
        else $error("full step wrong"); // see R18
    c_step: cover property (@(posedge core_clk) step_edge);
    c_mixed: cover property (@(posedge core_clk) step_edge && fall_a);
    c_fault: cover property (@(posedge core_clk) fault && !hold_home);
endmodule : mtc_translator
`default_nettype wire

// ===== tb/mtc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module mtc_host_model (
    input wire logic core_clk,
    output var logic step_in,
    output var logic dir_in,
    output var logic resolution_sel_lo,
    output var logic resolution_sel_hi,
    output var logic sleep_n
);
    // Idle host: step low, awake
    initial begin
        step_in = 1'b0;
        dir_in = 1'b0;
        resolution_sel_lo = 1'b0;
        resolution_sel_hi = 1'b0;
        sleep_n = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #10;
    endtask : wt

    // Mode lines settle before the edge, which the sync stages need
    task automatic step(input logic d, input logic [1:0] r);
        wt(1);
        dir_in = d;
        {resolution_sel_hi, resolution_sel_lo} = r;
        wt(3);
        step_in = 1'b1;
        wt(4);
        step_in = 1'b0;
        wt(4);
    endtask : step

    // Pump settling after wake: 1 ms is 10000 cycles
    task automatic wake();
        sleep_n = 1'b1;
        wt(10000);
    endtask : wake
endmodule : mtc_host_model
`default_nettype wire

// ===== tb/mtc_translator_tb.sv
`timescale 1ns/10ps
`default_nettype none
module microstep_translator_chopper_tb;
    import mtc_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic step_in, dir_in, res_lo, res_hi, sleep_n;
    logic out_disable = 1'b0;
    logic reset_in_n = 1'b1;
    logic off_time_high = 1'b0;
    logic [11:0] off_time_set = 12'h028;
    logic [13:0] full_scale = 14'h00C8;
    logic sense_a = 1'b0;
    logic sense_b = 1'b0;
    logic zero_a = 1'b0;
    logic zero_b = 1'b0;
    logic [2:0] fault = 3'h0;
    logic lockout = 1'b0;
    mtc_bridge_t bridge_a, bridge_b;
    mtc_level_t level_a, level_b;
    logic [27:0] trip_a, trip_b;
    logic mixed_a, mixed_b, pump_on, outputs_on;
    logic [5:0] position;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;

    always #50 core_clk = ~core_clk;

    mtc_host_model mtc_host_model_inst (.core_clk(core_clk),
        .step_in(step_in), .dir_in(dir_in), .resolution_sel_lo(res_lo),
        .resolution_sel_hi(res_hi), .sleep_n(sleep_n));

    mtc_translator mtc_translator_inst (.core_clk(core_clk), .rst_n(rst_n),
        .step_in(step_in), .dir_in(dir_in), .resolution_sel_lo(res_lo),
        .resolution_sel_hi(res_hi), .out_disable(out_disable),
        .sleep_n(sleep_n), .reset_in_n(reset_in_n),
        .off_time_high(off_time_high), .off_time_set(off_time_set),
        .full_scale_trip_current(full_scale),
        .phase_a_current_sense(sense_a), .phase_b_current_sense(sense_b),
        .phase_a_zero(zero_a), .phase_b_zero(zero_b),
        .over_temp(fault[0]), .gate_pump_low(fault[1]),
        .sink_gate_regulator_fault(fault[2]),
        .power_on_lockout(lockout), .bridge_a(bridge_a),
        .bridge_b(bridge_b), .level_a(level_a), .level_b(level_b),
        .trip_a(trip_a), .trip_b(trip_b), .mixed_a(mixed_a),
        .mixed_b(mixed_b), .position(position), .pump_on(pump_on),
        .outputs_on(outputs_on));

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #10;
    endtask : wt

    task automatic chk(input logic [27:0] got, input logic [27:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // Steps during reset-in are dropped and outputs stay off
    task automatic go_home();
        reset_in_n = 1'b0;
        mtc_host_model_inst.step(1'b1, 2'h3);
        chk(28'(position), 28'h000_0008);
        chk(28'(outputs_on), 28'h000_0000);
        reset_in_n = 1'b1;
        wt(6);
    endtask : go_home

    task automatic t_modes();
        logic [5:0] inc [4] = '{6'h10, 6'h08, 6'h04, 6'h01};
        for (int r = 0; r < 4; r++) begin
            go_home();
            mtc_host_model_inst.step(1'b1, 2'(r));
            chk(28'(position), 28'(6'h08 + inc[r]));
        end
        // One sixteenth up from home: A falls, B rises
        chk(28'(level_a), 28'h000_18C8);
        chk(28'(level_b), 28'h000_1E32);
        chk(trip_a, 28'h000_3190);
        chk(trip_b, 28'h000_3C64);
        chk(28'({mixed_a, mixed_b}), 28'h000_0002);
        // Full step to 135 degrees: equal magnitude keeps slow decay
        go_home();
        mtc_host_model_inst.step(1'b1, 2'h0);
        chk(28'(level_a), 28'h000_5B9F);
        chk(28'({mixed_a, mixed_b}), 28'h000_0000);
        go_home();
        mtc_host_model_inst.step(1'b0, 2'h0);
        chk(28'(position), 28'h000_0038);
        $display("modes test done");
    endtask : t_modes

    task automatic t_disable();
        logic [5:0] p;
        out_disable = 1'b1;
        wt(5);
        chk(28'({outputs_on, bridge_a}), 28'h000_0000);
        chk(28'(bridge_b), 28'h000_0000);
        p = position;
        mtc_host_model_inst.step(1'b1, 2'h3);
        chk(28'(position), 28'(p + 6'h01));
        out_disable = 1'b0;
        wt(5);
        chk(28'(outputs_on), 28'h000_0001);
        $display("disable test done");
    endtask : t_disable

    task automatic t_faults();
        for (int f = 0; f < 3; f++) begin
            fault = 3'h1 << f;
            wt(4);
            chk(28'({outputs_on, bridge_a}), 28'h000_0000);
            fault = 3'h0;
            wt(5);
            chk(28'(outputs_on), 28'h000_0001);
        end
        lockout = 1'b1;
        wt(5);
        chk(28'({outputs_on, position}), 28'h000_0008);
        lockout = 1'b0;
        wt(5);
        $display("fault test done");
    endtask : t_faults

    task automatic t_sleep();
        mtc_host_model_inst.step(1'b1, 2'h3);
        mtc_host_model_inst.sleep_n = 1'b0;
        wt(5);
        chk(28'({pump_on, outputs_on}), 28'h000_0000);
        mtc_host_model_inst.wake();
        chk(28'({pump_on, position}), 28'h000_0048);
        $display("sleep test done");
    endtask : t_sleep

    // Off period length measured as time away from the on pattern
    task automatic t_chop();
        int n;
        int off;
        mtc_bridge_t on_q;
        for (int k = 0; k < 2; k++) begin
            off_time_high = k[0];
            off = (k == 1) ? 300 : 40;
            wt(20);
            on_q = bridge_a;
            sense_a = 1'b1;
            n = 0;
            while (bridge_a === on_q && n < 10) begin
                n++;
                wt(1);
            end
            sense_a = 1'b0;
            n = 0;
            while (bridge_a !== on_q && n < 400) begin
                n++;
                wt(1);
            end
            chk(28'(n >= off - 2 && n <= off + 2), 28'h000_0001);
        end
        $display("chop test done");
    endtask : t_chop

    // Hang guard well above the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            report_and_stop();
        end
    end

    initial begin
        repeat (16) @(posedge core_clk);
        #10;
        rst_n = 1'b1;
        wt(8);
        chk(28'(position), 28'h000_0008);
        chk(28'({mixed_a, mixed_b}), 28'h000_0003);
        chk(28'(level_b), 28'h000_1B9F);
        t_modes();
        t_disable();
        t_faults();
        t_sleep();
        t_chop();
        report_and_stop();
    end
endmodule : microstep_translator_chopper_tb
`default_nettype wire
